/* File: hdl/mppc_regs.sv */
/*
  Master-page power-down and configuration register bank of a dual-channel converter.
  Assumes the serial control port decodes each transfer into i_wr_en or i_rd_en
  with an 8-bit address, data valid in the same cycle, all synchronous to i_clk.
*/
// Summary of operation
// - Bit 5 of the global register picks mask 1 when low, mask 2 when high.
// - Mask 1 is formed by the registers at 20h and 21h.
// - Mask 2 is formed by the registers at 23h and 24h.
// - Each channel buffer field controls two buffers, each feeding two cores.
// - Buffer code 00 keeps both active, 11 powers both down; host avoids 01, 10.
// - In 24h, channel B buffers use bits 7-6, channel A bits 5-4, reset zero.
// - Global power-down bit high powers the whole device down while the override bit is high.
// - Override bit high makes the device ignore the power-down pin.
// - Performance bits sit at 39h bits 7-6, 3Ah bit 6, 56h bit 2.
// - Input dc-coupling bit at 4Fh bit 0 selects the high bias resistance.
// - Sysref_control holds sysref ignore bit 6, common mode bit 1, level bit 0.
// - Register power-down enable at 55h applies the selected mask when high.
// - Ignore bit blocks the sysref input; level bit drives internal sysref.
`timescale 1ns/1ns
`default_nettype none
module mppc_regs (
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_resetn,
  // Register access from the serial control port
  input  wire logic                                i_wr_en,
  input  wire logic                                i_rd_en,
  input  wire logic [mppc_pkg::MPPC_AW-1:0]        i_addr,
  input  wire logic [mppc_pkg::MPPC_DW-1:0]        i_wdata,
  output logic      [mppc_pkg::MPPC_DW-1:0]        o_rdata,
  // Device pins
  input  wire logic                                i_powerdown_pin,
  input  wire logic                                i_sysref,
  // Controls to the analog side
  output logic                                     o_whole_device_powerdown,
  output logic      [3:0]                          o_chan_a_core_powerdown,
  output logic      [3:0]                          o_chan_b_core_powerdown,
  output logic      [1:0]                          o_chan_a_buffer_powerdown,
  output logic      [1:0]                          o_chan_b_buffer_powerdown,
  output logic      [3:0]                          o_performance_setting,
  output logic                                     o_input_dc_bias_enable,
  output logic                                     o_sysref_high_common_mode_enable,
  output logic                                     o_sysref_internal
);
  import mppc_pkg::*;

  // ==========================================================================
  // Register instances
  // ==========================================================================
  localparam logic [7:0] OFS [MPPC_NREG] = '{
    MPPC_OFS_MASK1_CORES, MPPC_OFS_MASK1_BUFFERS, MPPC_OFS_MASK2_CORES,
    MPPC_OFS_MASK2_BUFFERS, MPPC_OFS_WHOLE_DEVICE_POWERDOWN, MPPC_OFS_PERF_LOW,
    MPPC_OFS_PERF_BIT2, MPPC_OFS_INPUT_COUPLE, MPPC_OFS_SYSREF, MPPC_OFS_PERF_BIT3};
  // Reserved bits are masked off so a careless write cannot alter behaviour.
  localparam logic [7:0] MSK [MPPC_NREG] = '{
    MPPC_RW_CORES, MPPC_RW_BUFFERS, MPPC_RW_CORES, MPPC_RW_BUFFERS,
    MPPC_RW_GLOBAL, MPPC_RW_PERF_LOW, MPPC_RW_PERF_BIT2, MPPC_RW_COUPLE,
    MPPC_RW_SYSREF, MPPC_RW_PERF_BIT3};

  wire [7:0] val [MPPC_NREG];
  wire [7:0] reg_pdn_val;

  // Each register decodes its own write strobe from the shared offset table.
  genvar g;
  generate
    for (g = 0; g < MPPC_NREG; g++) begin : g_reg
      mppc_byte_reg #(
        .RW_MASK   (MSK[g]),
        .RESET_VAL (MPPC_RESET_VALUE)
      ) u_reg (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_we     (i_wr_en && (i_addr == OFS[g])),
        .i_wdata  (i_wdata),
        .o_value  (val[g])
      );
    end
  endgenerate

  // The power-down enable at 55h is kept separately since it is not read back
  // through the shared table in order to keep the mux short.
  mppc_byte_reg #(
    .RW_MASK   (MPPC_RW_REG_PDN),
    .RESET_VAL (MPPC_RESET_VALUE)
  ) u_reg_pdn (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (i_wr_en && (i_addr == MPPC_OFS_REG_PDN)),
    .i_wdata  (i_wdata),
    .o_value  (reg_pdn_val)
  );

  // ==========================================================================
  // Named register views
  // ==========================================================================
  // The views only rename table entries; the table order fixes which is which.
  wire [7:0] mask1_cores_reg   = val[0];
  wire [7:0] mask1_buffers_reg = val[1];
  wire [7:0] mask2_cores_reg   = val[2];
  wire [7:0] mask2_input_buffer_powerdown_reg = val[3];
  wire [7:0] global_powerdown_control_reg     = val[4];
  wire [7:0] performance_setting_low_reg      = val[5];
  wire [7:0] performance_setting_bit2_reg     = val[6];
  wire [7:0] input_coupling_control_reg       = val[7];
  wire [7:0] sysref_control_reg               = val[8];
  wire [7:0] performance_setting_bit3_reg     = val[9];

  // ==========================================================================
  // Read decode
  // ==========================================================================
  // Every register value is an argument, so the assignment below re-evaluates
  // whenever a register changes, not only when the address or strobe does.
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] regs [MPPC_NREG],
                                          input logic [7:0] pdn);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < MPPC_NREG; i++) begin
      if (addr == OFS[i]) begin
        r = regs[i];
      end
    end
    if (addr == MPPC_OFS_REG_PDN) begin
      r = pdn;
    end
    return r;
  endfunction : read_mux

  wire [7:0] rdata_next = i_rd_en ? read_mux(i_addr, val, reg_pdn_val) : o_rdata;

  // ==========================================================================
  // Power-down selection
  // ==========================================================================
  wire mask_sel    = global_powerdown_control_reg[MPPC_MSEL_BIT];
  wire reg_pdn_en  = reg_pdn_val[MPPC_REGPDN_BIT];
  wire pin_ignored = global_powerdown_control_reg[MPPC_OVRD_BIT];
  wire gpdn_bit    = global_powerdown_control_reg[MPPC_GPDN_BIT];

  // Both halves of a mask switch together, so cores and buffers never mix masks.
  function automatic logic [7:0] pick_mask(input logic       sel,
                                           input logic [7:0] set1,
                                           input logic [7:0] set2);
    return sel ? set2 : set1;
  endfunction : pick_mask

  wire [7:0] sel_cores   = pick_mask(mask_sel, mask1_cores_reg, mask2_cores_reg);
  wire [7:0] sel_buffers = pick_mask(mask_sel, mask1_buffers_reg,
                                     mask2_input_buffer_powerdown_reg);

  // Register power-down follows the register bit once the pin is overridden;
  // otherwise the pin level rules. This order is why the override must come first.
  wire whole_next = pin_ignored ? gpdn_bit : i_powerdown_pin;

  // Buffer fields pass as stored; codes 01 and 10 are host misuse and not corrected.
  wire [1:0] buf_b_next = reg_pdn_en ? sel_buffers[MPPC_BUF_B_HI:MPPC_BUF_B_LO]
                                     : MPPC_BUF_ACTIVE;
  wire [1:0] buf_a_next = reg_pdn_en ? sel_buffers[MPPC_BUF_A_HI:MPPC_BUF_A_LO]
                                     : MPPC_BUF_ACTIVE;
  // Channel A cores sit in the high nibble of a cores register, channel B in the low.
  wire [3:0] core_a_next = reg_pdn_en ? sel_cores[7:4] : 4'h0;
  wire [3:0] core_b_next = reg_pdn_en ? sel_cores[3:0] : 4'h0;

  // ==========================================================================
  // Performance, coupling and sysref
  // ==========================================================================
  // The field spans three registers; the host writes them as one setting.
  wire [3:0] perf_next = {performance_setting_bit3_reg[MPPC_PERF3_BIT],
                          performance_setting_bit2_reg[MPPC_PERF2_BIT],
                          performance_setting_low_reg[MPPC_PERF_HI:MPPC_PERF_LO]};
  wire dcin_next = input_coupling_control_reg[MPPC_DCIN_BIT];
  wire srcm_next = sysref_control_reg[MPPC_SRCM_BIT];
  // An ignored sysref input is replaced by the software level, never by a constant.
  wire sysref_next = sysref_control_reg[MPPC_IGSR_BIT] ? sysref_control_reg[MPPC_SWSR_BIT]
                                                       : i_sysref;

  // ==========================================================================
  // Output flops
  // ==========================================================================
  // Read data holds between reads, so the port may shift it out late.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // Power-down controls are registered so no decode glitch reaches the analog side.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_whole_device_powerdown  <= 1'b0;
      o_chan_a_core_powerdown   <= 4'h0;
      o_chan_b_core_powerdown   <= 4'h0;
      o_chan_a_buffer_powerdown <= 2'h0;
      o_chan_b_buffer_powerdown <= 2'h0;
    end else begin
      o_whole_device_powerdown  <= whole_next;
      o_chan_a_core_powerdown   <= core_a_next;
      o_chan_b_core_powerdown   <= core_b_next;
      o_chan_a_buffer_powerdown <= buf_a_next;
      o_chan_b_buffer_powerdown <= buf_b_next;
    end
  end

  // Performance, coupling and sysref controls.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_performance_setting            <= 4'h0;
      o_input_dc_bias_enable           <= 1'b0;
      o_sysref_high_common_mode_enable <= 1'b0;
      o_sysref_internal                <= 1'b0;
    end else begin
      o_performance_setting            <= perf_next;
      o_input_dc_bias_enable           <= dcin_next;
      o_sysref_high_common_mode_enable <= srcm_next;
      o_sysref_internal                <= sysref_next;
    end
  end

endmodule : mppc_regs
`default_nettype wire

/* File: hdl/mppc_pkg.sv */
/*
  Package for the master-page power and configuration register bank.
  Holds offsets, field positions, reset values and the register write port width.
  Assumes the serial control port has already turned each access into an
  8-bit address, an 8-bit data byte and one-cycle strobes.
*/
package mppc_pkg;

  // ==========================================================================
  // Widths and offsets
  // ==========================================================================
  localparam int unsigned MPPC_AW = 8;
  localparam int unsigned MPPC_DW = 8;

  localparam logic [7:0] MPPC_OFS_MASK1_CORES   = 8'h20;
  localparam logic [7:0] MPPC_OFS_MASK1_BUFFERS = 8'h21;
  localparam logic [7:0] MPPC_OFS_MASK2_CORES   = 8'h23;
  localparam logic [7:0] MPPC_OFS_MASK2_BUFFERS = 8'h24;
  localparam logic [7:0] MPPC_OFS_WHOLE_DEVICE_POWERDOWN    = 8'h26;
  localparam logic [7:0] MPPC_OFS_PERF_LOW      = 8'h39;
  localparam logic [7:0] MPPC_OFS_PERF_BIT2     = 8'h3a;
  localparam logic [7:0] MPPC_OFS_INPUT_COUPLE  = 8'h4f;
  localparam logic [7:0] MPPC_OFS_SYSREF        = 8'h53;
  localparam logic [7:0] MPPC_OFS_REG_PDN       = 8'h55;
  localparam logic [7:0] MPPC_OFS_PERF_BIT3     = 8'h56;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned MPPC_BUF_B_HI   = 7;
  localparam int unsigned MPPC_BUF_B_LO   = 6;
  localparam int unsigned MPPC_BUF_A_HI   = 5;
  localparam int unsigned MPPC_BUF_A_LO   = 4;
  localparam int unsigned MPPC_GPDN_BIT   = 7;
  localparam int unsigned MPPC_OVRD_BIT   = 6;
  localparam int unsigned MPPC_MSEL_BIT   = 5;
  localparam int unsigned MPPC_PERF_HI    = 7;
  localparam int unsigned MPPC_PERF_LO    = 6;
  localparam int unsigned MPPC_PERF2_BIT  = 6;
  localparam int unsigned MPPC_PERF3_BIT  = 2;
  localparam int unsigned MPPC_DCIN_BIT   = 0;
  localparam int unsigned MPPC_IGSR_BIT   = 6;
  localparam int unsigned MPPC_SRCM_BIT   = 1;
  localparam int unsigned MPPC_SWSR_BIT   = 0;
  localparam int unsigned MPPC_REGPDN_BIT = 4;

  // ==========================================================================
  // Reset values, writable masks and buffer codes
  // ==========================================================================
  localparam logic [7:0] MPPC_RESET_VALUE  = 8'h00;
  localparam logic [7:0] MPPC_RW_BUFFERS   = 8'hf0;
  localparam logic [7:0] MPPC_RW_GLOBAL    = 8'he0;
  localparam logic [7:0] MPPC_RW_PERF_LOW  = 8'hc0;
  localparam logic [7:0] MPPC_RW_PERF_BIT2 = 8'h40;
  localparam logic [7:0] MPPC_RW_COUPLE    = 8'h01;
  localparam logic [7:0] MPPC_RW_SYSREF    = 8'h43;
  localparam logic [7:0] MPPC_RW_REG_PDN   = 8'h10;
  localparam logic [7:0] MPPC_RW_PERF_BIT3 = 8'h04;
  localparam logic [7:0] MPPC_RW_CORES     = 8'hff;
  localparam logic [1:0] MPPC_BUF_ACTIVE   = 2'h0;
  localparam logic [1:0] MPPC_BUF_OFF      = 2'h3;

  // Number of registers in the shared offset table; the enable at 55h is held apart.
  localparam int unsigned MPPC_NREG = 10;

endpackage : mppc_pkg

/* File: hdl/mppc_byte_reg.sv */
/*
  One 8-bit configuration register with a per-bit writable mask.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mppc_byte_reg #(
  parameter logic [7:0] RW_MASK   = 8'hff,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Write port
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  // Stored value
  output logic      [7:0] o_value
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Bits outside RW_MASK have no function, so they are never stored and read as zero.
  logic [7:0] value_reg;
  wire  [7:0] value_next = i_we ? (i_wdata & RW_MASK) : value_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign o_value = value_reg;

endmodule : mppc_byte_reg
`default_nettype wire

/* File: sim/mppc_sva.sv */
/* Checker on the register bank ports: field routing delays and readback values.
   Assumes one clock, active-low reset and one-cycle access strobes. */
`timescale 1ns/1ns
`default_nettype none
module mppc_sva (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] o_performance_setting,
  input wire logic       o_input_dc_bias_enable,
  input wire logic       o_sysref_high_common_mode_enable
);
  // Address 00h is unmapped, so it can stand for no access at all.
  wire logic [7:0] wa = i_wr_en ? i_addr : 8'h00;
  wire logic [7:0] ra = (i_rd_en && !i_wr_en) ? i_addr : 8'h00;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_perf_low: assert property (wa == 8'h39 |-> ##2
    o_performance_setting[1:0] == $past(i_wdata[7:6], 2)) else $error("perf low bits");
  a_perf_mid: assert property (wa == 8'h3a |-> ##2
    o_performance_setting[2] == $past(i_wdata[6], 2)) else $error("perf bit two");
  a_perf_top: assert property (wa == 8'h56 |-> ##2
    o_performance_setting[3] == $past(i_wdata[2], 2)) else $error("perf bit three");
  a_dc_bias: assert property (wa == 8'h4f |=> ##1
    o_input_dc_bias_enable == $past(i_wdata[0], 2)) else $error("dc bias");
  a_sysref_mode: assert property (wa == 8'h53 ##2 1'b1 |->
    o_sysref_high_common_mode_enable == $past(i_wdata[1], 2)) else $error("sysref mode");
  a_buf_readback: assert property (wa == 8'h24 ##1 ra == 8'h24 |=>
    o_rdata == ($past(i_wdata, 2) & 8'hf0)) else $error("buffer readback");
  a_sref_readback: assert property (wa == 8'h53 ##1 ra == 8'h53 |=>
    o_rdata == ($past(i_wdata, 2) & 8'h43)) else $error("sysref readback");
  a_gpd_readback: assert property (wa == 8'h26 ##1 ra == 8'h26 |=>
    o_rdata == ($past(i_wdata, 2) & 8'he0)) else $error("global readback");
endmodule : mppc_sva
bind mppc_regs mppc_sva i_mppc_sva (.i_clk, .i_resetn, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
  .o_rdata, .o_performance_setting, .o_input_dc_bias_enable, .o_sysref_high_common_mode_enable);
`default_nettype wire

/* File: sim/mppc_host.sv */
/* Host model: drives register writes and reads on the bank's access port.
   Assumes each task is entered at a falling clock edge and ends at one. */
`timescale 1ns/1ns
`default_nettype none
module mppc_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en = 1'b0,
  output logic            o_rd_en = 1'b0,
  output logic      [7:0] o_addr = 8'h00,
  output logic      [7:0] o_wdata = 8'h00
);
  import mppc_pkg::*;
  // Writable bits per register; reserved bits are always sent as zero.
  function automatic logic [7:0] rwm(input logic [7:0] a);
    case (a)
      MPPC_OFS_MASK1_CORES, MPPC_OFS_MASK2_CORES:     return MPPC_RW_CORES;
      MPPC_OFS_MASK1_BUFFERS, MPPC_OFS_MASK2_BUFFERS: return MPPC_RW_BUFFERS;
      MPPC_OFS_WHOLE_DEVICE_POWERDOWN:   return MPPC_RW_GLOBAL;
      MPPC_OFS_PERF_LOW:     return MPPC_RW_PERF_LOW;
      MPPC_OFS_PERF_BIT2:    return MPPC_RW_PERF_BIT2;
      MPPC_OFS_INPUT_COUPLE: return MPPC_RW_COUPLE;
      MPPC_OFS_SYSREF:       return MPPC_RW_SYSREF;
      MPPC_OFS_REG_PDN:      return MPPC_RW_REG_PDN;
      MPPC_OFS_PERF_BIT3:    return MPPC_RW_PERF_BIT3;
      default:               return 8'h00;
    endcase
  endfunction : rwm
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    o_addr = a;
    o_wdata = v & rwm(a);
    o_wr_en = 1'b1;
    @(negedge i_clk);
    o_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    v = i_rdata;
  endtask : rd
endmodule : mppc_host
`default_nettype wire

/* File: sim/testbench.sv */
/* Bench: random register traffic compared with a behavioural model after every access.
   Assumes the host model and the checker are compiled first; clock 125 MHz. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mppc_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, pin = 1'b0, sysref = 1'b0;
  logic [7:0] ad, d, c, b, q, m [256];
  int errors = 0, compares = 0, seed = 56;
  wire logic wr_en, rd_en;
  wire logic [7:0] addr, wdata, rdat;
  wire logic [19:0] outs;
  logic [7:0] tbl [12] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h26, 8'h39, 8'h3a, 8'h4f,
    8'h53, 8'h55, 8'h56, 8'h30};
  always #4 clk = ~clk;
  mppc_host i_mppc_host (.i_clk(clk), .i_rdata(rdat), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));
  mppc_regs i_mppc_regs (.i_clk(clk), .i_resetn(resetn), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdat), .i_powerdown_pin(pin), .i_sysref(sysref),
    .o_whole_device_powerdown(outs[19]), .o_chan_a_core_powerdown(outs[18:15]),
    .o_chan_b_core_powerdown(outs[14:11]), .o_chan_a_buffer_powerdown(outs[10:9]),
    .o_chan_b_buffer_powerdown(outs[8:7]), .o_performance_setting(outs[6:3]),
    .o_input_dc_bias_enable(outs[2]), .o_sysref_high_common_mode_enable(outs[1]),
    .o_sysref_internal(outs[0]));
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    i_mppc_host.wr(a, v);
    m[a] = v & i_mppc_host.rwm(a);
    i_mppc_host.rd(a, q);
    chk("readback", {12'h000, m[a]}, {12'h000, q});
  endtask : put
  task automatic do_reset;
    resetn = 1'b0;
    foreach (m[i]) m[i] = 8'h00;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    foreach (tbl[i]) begin
      i_mppc_host.rd(tbl[i], q);
      chk("reset value", 20'h00000, {12'h000, q});
      @(negedge clk);
    end
    $display("test reset_values done");
  endtask : do_reset
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    do_reset();
    for (int n = 0; n < 300; n++) begin
      ad = tbl[$unsigned($random(seed)) % 12];
      d = 8'($random(seed));
      if (ad == 8'h21 || ad == 8'h24) d[7:4] = {{2{d[7]}}, {2{d[5]}}};
      if (ad == 8'h26) d[7] = d[7] & d[6] & m[8'h26][6];
      if (ad inside {8'h39, 8'h3a, 8'h56}) begin
        put(8'h39, {d[1:0], 6'h00});
        put(8'h3a, {1'b0, d[2], 6'h00});
        put(8'h56, {5'h00, d[3], 2'h0});
      end else begin
        put(ad, d);
      end
      {pin, sysref} = 2'($random(seed));
      repeat (2) @(negedge clk);
      c = (m[8'h26][5] ? m[8'h23] : m[8'h20]) & {8{m[8'h55][4]}};
      b = (m[8'h26][5] ? m[8'h24] : m[8'h21]) & {8{m[8'h55][4]}};
      chk("outputs", {m[8'h26][6] ? m[8'h26][7] : pin, c, b[5:4], b[7:6], m[8'h56][2],
        m[8'h3a][6], m[8'h39][7:6], m[8'h4f][0], m[8'h53][1], m[8'h53][6] ? m[8'h53][0] : sysref}, outs);
      if (n == 150) do_reset();
    end
    $display("test random_access done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
